/* speed_neg_map.vh */
// Constants for the link speed negotiation timing block.
`ifndef SPEED_NEG_MAP_VH
`define SPEED_NEG_MAP_VH

`define CLK_PERIOD_PS 8000
`define MS_IN_PS 1000000000
`define CYCLES_PER_MS (`MS_IN_PS / `CLK_PERIOD_PS)

`define T_RXCYCL_MS 13'h001e
`define T_TXCYCL_MS 13'h009a
`define T_WFS_TX_MS 13'h00b8
`define T_SLOW_TX_MS 13'h00b8
`define T_LEAD_TX_MS 13'h00d6
`define T_TRAIL_MS 13'h00f7
`define T_WAKE_MS 13'h0384
`define T_SLEEP_MS 13'h1388
`define T_SLOW_ENTRY_MS 13'h03e8

`define LOS_LIMIT_CYC 6'h20
`define MAX_SPEED 2'h3
`define STAGE_RESET 3'h0

`endif

/* ms_tick_gen.v */
// Millisecond tick generator from the system clock.
`timescale 1ns/1ps
`default_nettype none
module ms_tick_gen #(
    parameter integer CYCLES_PER_MS = 125000
) (
    input wire clock_in, // System clock.
    input wire rst_n_in, // Asynchronous reset, active low.
    input wire clk_en_in, // Clock enable.
    input wire clear_in, // Restarts the millisecond.
    output reg tick_out // One-cycle pulse per millisecond.
);
    reg [16:0] count_q;

    always @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            count_q <= 17'h00000;
            tick_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (clear_in || count_q == CYCLES_PER_MS[16:0] - 17'h00001)
            begin
                count_q <= 17'h00000;
                tick_out <= !clear_in;
            end
            else
            begin
                count_q <= count_q + 17'h00001;
                tick_out <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* speed_neg_timing.v */
// Link speed negotiation stage and speed dwell timing for a loop port.
`timescale 1ns/1ps
`default_nettype none
`include "speed_neg_map.vh"
module speed_neg_timing #(
    parameter integer CYCLES_PER_MS = `CYCLES_PER_MS
) (
    input wire clock_in, // System clock, 125 MHz.
    input wire rst_n_in, // Asynchronous reset, active low.
    input wire clk_en_in, // Freezes all state while low.
    input wire link_clk_in, // Recovered receive clock pin.
    input wire rx_sync_in, // Receiver reports sync at its speed.
    input wire slow_wait_en_in, // Enables the low-rate-wait stage.
    input wire settled_port_state_in, // Port in settled port state.
    output reg [1:0] tx_speed_out, // Transmit speed index.
    output reg [1:0] rx_speed_out, // Receive speed index.
    output reg send_lip_out, // Transmit loop initialization primitive.
    output reg [2:0] stage_out, // Current stage.
    output reg done_out, // Negotiation finished.
    output reg signal_out // Incoming signal present.
);
    localparam [2:0] ST_WAIT = 3'h0;
    localparam [2:0] ST_SLOW = 3'h1;
    localparam [2:0] ST_LEAD = 3'h2;
    localparam [2:0] ST_TRAIL = 3'h3;
    localparam [2:0] ST_DONE = 3'h4;

    // Next lower speed, wrapping from the lowest back to the maximum.
    function [1:0] step_down;
        input [1:0] s;
        begin
            step_down = (s == 2'h0) ? `MAX_SPEED : s - 2'h1;
        end
    endfunction

    // Saturating millisecond count.
    function [12:0] ms_inc;
        input [12:0] t;
        begin
            ms_inc = (t == 13'h1fff) ? t : t + 13'h0001;
        end
    endfunction

    reg [2:0] stage_q;
    reg [1:0] tx_q;
    reg [1:0] rx_q;
    reg [12:0] tx_ms_q;
    reg [12:0] rx_ms_q;
    reg [12:0] stage_ms_q;
    reg wake_q;
    reg quick_q;
    reg [2:0] link_q;
    reg [1:0] sync_q;
    reg [5:0] act_q;
    reg restart_q;
    wire tick;
    wire link_edge;
    wire signal_w;
    wire sync_ok;
    wire rx_end;
    wire match;

    ms_tick_gen #(
        .CYCLES_PER_MS(CYCLES_PER_MS)
    ) u_tick (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .clear_in(restart_q),
        .tick_out(tick)
    );

    // The first stage of each synchroniser feeds only the second.
    assign link_edge = link_q[2] ^ link_q[1];
    assign signal_w = act_q < `LOS_LIMIT_CYC;
    assign sync_ok = sync_q[1] && signal_w;
    assign rx_end = tick && (rx_ms_q >= `T_RXCYCL_MS - 13'h0001);
    assign match = sync_ok && (rx_q == tx_q);

    always @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            link_q <= 3'h0;
            sync_q <= 2'h0;
            act_q <= `LOS_LIMIT_CYC;
        end
        else if (clk_en_in)
        begin
            link_q <= {link_q[1:0], link_clk_in};
            sync_q <= {sync_q[0], rx_sync_in};
            if (link_edge)
                act_q <= 6'h00;
            else if (act_q != 6'h3f)
                act_q <= act_q + 6'h01;
        end
    end

    // A speed or stage change clears the matching timers in the same cycle; the
    // later assignments in this block override the tick increments.
    always @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            stage_q <= `STAGE_RESET;
            tx_q <= `MAX_SPEED;
            rx_q <= `MAX_SPEED;
            tx_ms_q <= 13'h0000;
            rx_ms_q <= 13'h0000;
            stage_ms_q <= 13'h0000;
            wake_q <= 1'b0;
            quick_q <= 1'b0;
            restart_q <= 1'b1;
        end
        else if (clk_en_in)
        begin
            restart_q <= 1'b0;
            if (tick)
            begin
                tx_ms_q <= ms_inc(tx_ms_q);
                rx_ms_q <= ms_inc(rx_ms_q);
                stage_ms_q <= ms_inc(stage_ms_q);
            end
            case (stage_q)
                ST_WAIT:
                begin
                    if (tick && tx_ms_q >= `T_WFS_TX_MS - 13'h0001)
                    begin
                        tx_q <= step_down(tx_q);
                        tx_ms_q <= 13'h0000;
                    end
                    if (rx_end)
                    begin
                        if (sync_ok)
                        begin
                            stage_q <= ST_LEAD;
                            quick_q <= (rx_q == `MAX_SPEED);
                            tx_q <= `MAX_SPEED;
                            tx_ms_q <= 13'h0000;
                            rx_ms_q <= 13'h0000;
                            stage_ms_q <= 13'h0000;
                        end
                        else
                        begin
                            rx_q <= step_down(rx_q);
                            rx_ms_q <= 13'h0000;
                        end
                    end
                    else if (tick && slow_wait_en_in && !signal_w &&
                             stage_ms_q >= `T_SLOW_ENTRY_MS - 13'h0001)
                    begin
                        stage_q <= ST_SLOW;
                        wake_q <= 1'b0;
                        rx_q <= tx_q;
                        tx_ms_q <= 13'h0000;
                        rx_ms_q <= 13'h0000;
                        stage_ms_q <= 13'h0000;
                    end
                end
                ST_SLOW:
                begin
                    if (wake_q)
                    begin
                        // Fast receiver stepping while awake.
                        if (tick && tx_ms_q >= `T_SLOW_TX_MS - 13'h0001)
                        begin
                            tx_q <= step_down(tx_q);
                            tx_ms_q <= 13'h0000;
                        end
                        if (rx_end)
                        begin
                            if (sync_ok)
                            begin
                                stage_q <= ST_LEAD;
                                quick_q <= (rx_q == `MAX_SPEED);
                                tx_q <= `MAX_SPEED;
                                tx_ms_q <= 13'h0000;
                                rx_ms_q <= 13'h0000;
                                stage_ms_q <= 13'h0000;
                            end
                            else
                            begin
                                rx_q <= step_down(rx_q);
                                rx_ms_q <= 13'h0000;
                            end
                        end
                        else if (tick && stage_ms_q >= `T_WAKE_MS - 13'h0001)
                        begin
                            wake_q <= 1'b0;
                            rx_q <= tx_q;
                            rx_ms_q <= 13'h0000;
                            stage_ms_q <= 13'h0000;
                        end
                    end
                    else
                    begin
                        // Slow sampling: receiver follows the transmitter rate.
                        if (tick && tx_ms_q >= `T_SLOW_TX_MS - 13'h0001)
                        begin
                            if (sync_ok)
                            begin
                                stage_q <= ST_LEAD;
                                quick_q <= (rx_q == `MAX_SPEED);
                                tx_q <= `MAX_SPEED;
                            end
                            else
                            begin
                                tx_q <= step_down(tx_q);
                                rx_q <= step_down(rx_q);
                            end
                            tx_ms_q <= 13'h0000;
                            rx_ms_q <= 13'h0000;
                            stage_ms_q <= sync_ok ? 13'h0000 : stage_ms_q;
                        end
                        else if (tick && (signal_w || stage_ms_q >= `T_SLEEP_MS - 13'h0001))
                        begin
                            wake_q <= 1'b1;
                            rx_ms_q <= 13'h0000;
                            stage_ms_q <= 13'h0000;
                        end
                    end
                end
                ST_LEAD:
                begin
                    if (quick_q)
                    begin
                        if (rx_end)
                        begin
                            quick_q <= 1'b0;
                            rx_ms_q <= 13'h0000;
                            if (match)
                            begin
                                stage_q <= ST_TRAIL;
                                stage_ms_q <= 13'h0000;
                            end
                        end
                    end
                    else
                    begin
                        // Receiver keeps hunting until it holds sync.
                        if (rx_end && !sync_ok)
                        begin
                            rx_q <= step_down(rx_q);
                            rx_ms_q <= 13'h0000;
                        end
                        else if (rx_end)
                            rx_ms_q <= 13'h0000;
                        if (tick && tx_ms_q >= `T_LEAD_TX_MS - 13'h0001)
                        begin
                            tx_ms_q <= 13'h0000;
                            if (match)
                            begin
                                stage_q <= ST_TRAIL;
                                rx_ms_q <= 13'h0000;
                                stage_ms_q <= 13'h0000;
                            end
                            else
                                tx_q <= step_down(tx_q);
                        end
                    end
                end
                ST_TRAIL:
                begin
                    // Speed is held; a lost sync restarts the search.
                    if (rx_end && !match)
                    begin
                        stage_q <= ST_WAIT;
                        tx_ms_q <= 13'h0000;
                        rx_ms_q <= 13'h0000;
                        stage_ms_q <= 13'h0000;
                    end
                    else if (tick && stage_ms_q >= `T_TRAIL_MS - 13'h0001)
                    begin
                        stage_q <= ST_DONE;
                        stage_ms_q <= 13'h0000;
                    end
                    else if (rx_end)
                        rx_ms_q <= 13'h0000;
                end
                ST_DONE:
                begin
                    if (!sync_ok)
                    begin
                        stage_q <= ST_WAIT;
                        tx_ms_q <= 13'h0000;
                        rx_ms_q <= 13'h0000;
                        stage_ms_q <= 13'h0000;
                    end
                end
                default:
                begin
                    stage_q <= `STAGE_RESET;
                    stage_ms_q <= 13'h0000;
                end
            endcase
        end
    end

    always @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            tx_speed_out <= `MAX_SPEED;
            rx_speed_out <= `MAX_SPEED;
            send_lip_out <= 1'b1;
            stage_out <= `STAGE_RESET;
            done_out <= 1'b0;
            signal_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            tx_speed_out <= tx_q;
            rx_speed_out <= rx_q;
            send_lip_out <= (stage_q != ST_DONE) && !settled_port_state_in;
            stage_out <= stage_q;
            done_out <= (stage_q == ST_DONE);
            signal_out <= signal_w;
        end
    end
endmodule
`default_nettype wire

/* hub_model.sv */
// Loop hub model that faces the negotiating port.
`timescale 1ns/1ps
`default_nettype none
module hub_model (
    input wire logic present_in, // Hub signal reaches the port.
    input wire logic negotiating_in, // Hub takes part in negotiation.
    input wire logic [1:0] hub_speed_in, // Hub operating speed.
    input wire logic [1:0] tx_speed_in, // Port transmit speed.
    input wire logic [1:0] rx_speed_in, // Port receive speed.
    input wire logic done_in, // Port has finished negotiating.
    output var logic link_clk_out, // Line clock seen by the port.
    output wire logic rx_sync_out, // Port receiver locked.
    output wire logic inserted_out // Port is on the loop.
);
    // The line clock stands still while no signal is presented, so no edge leaks into the port.
    // One process owns the clock so that it has a single driver from time zero on.
    initial
    begin
        link_clk_out = 1'b0;
        forever #62.5 link_clk_out = present_in ? !link_clk_out : 1'b0;
    end
    assign rx_sync_out = present_in && rx_speed_in == hub_speed_in;
    assign inserted_out = negotiating_in ? done_in : tx_speed_in == hub_speed_in;
endmodule
`default_nettype wire

/* speed_neg_timing_props.sv */
// Timing assertions for the speed negotiation block.
`timescale 1ns/1ps
`default_nettype none
module speed_neg_timing_props #(
    parameter integer CYCLES_PER_MS = 125000
) (
    input wire logic clock_in, // Clock.
    input wire logic rst_n_in, // Reset.
    input wire logic clk_en_in, // Enable.
    input wire logic link_clk_in, // Line clock.
    input wire logic rx_sync_in, // Sync.
    input wire logic slow_wait_en_in, // Slow stage enable.
    input wire logic settled_port_state_in, // Settled.
    input wire logic [1:0] tx_speed_out, // Tx speed.
    input wire logic [1:0] rx_speed_out, // Rx speed.
    input wire logic send_lip_out, // Primitive sent.
    input wire logic [2:0] stage_out, // Stage.
    input wire logic done_out, // Done.
    input wire logic signal_out // Signal.
);
    localparam integer C = CYCLES_PER_MS;
    logic [31:0] tx_n_q;
    logic [31:0] rx_n_q;
    logic [31:0] st_n_q;
    logic [1:0] tx_p_q;
    logic [1:0] rx_p_q;
    logic [2:0] st_p_q;
    wire tx_chg = tx_speed_out != tx_p_q;
    wire st_same = stage_out == st_p_q;
    // Counters hold while the enable is low because the design's millisecond timer freezes too.
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            tx_n_q <= 32'h0;
            rx_n_q <= 32'h0;
            st_n_q <= 32'h0;
            tx_p_q <= 2'h3;
            rx_p_q <= 2'h3;
            st_p_q <= 3'h0;
        end
        else if (clk_en_in)
        begin
            tx_n_q <= (tx_chg || !st_same) ? 32'h0 : tx_n_q + 32'h1;
            rx_n_q <= (rx_speed_out != rx_p_q || !st_same) ? 32'h0 : rx_n_q + 32'h1;
            st_n_q <= st_same ? st_n_q + 32'h1 : 32'h0;
            tx_p_q <= tx_speed_out;
            rx_p_q <= rx_speed_out;
            st_p_q <= stage_out;
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    // The middle sample is judged so a one-cycle skew between outputs cannot fire these.
    a_lip_while_neg: assert property ((clk_en_in && !settled_port_state_in && stage_out != 3'h4) [*3] |-> $past(send_lip_out))
        else $error("primitive not sent while negotiating");
    a_done_no_lip: assert property (done_out [*3] |-> !$past(send_lip_out))
        else $error("primitive still sent after done");
    a_lead_from_max: assert property (stage_out == 3'h2 && st_p_q != 3'h2 |-> tx_speed_out == 2'h3)
        else $error("lead stage not entered at maximum speed");
    a_lead_step_down: assert property (stage_out == 3'h2 && st_same && tx_chg |-> tx_speed_out == tx_p_q - 2'h1)
        else $error("lead speed not lowered by one step");
    a_wait_rx_step: assert property (stage_out == 3'h0 |-> rx_n_q <= 31 * C)
        else $error("receive speed held too long in wait");
    a_wait_tx_max: assert property (stage_out == 3'h0 |-> tx_n_q <= 185 * C)
        else $error("transmit speed held too long in wait");
    a_slow_tx_hold: assert property (stage_out == 3'h1 && st_same && tx_chg |-> tx_n_q >= 183 * C && tx_n_q <= 185 * C)
        else $error("slow stage transmit dwell wrong");
    a_lead_tx_max: assert property (stage_out == 3'h2 |-> tx_n_q <= 215 * C)
        else $error("transmit speed held too long in lead");
    a_lead_exit_match: assert property (stage_out == 3'h3 && st_p_q == 3'h2 |-> tx_speed_out == rx_speed_out)
        else $error("trail entered with unequal speeds");
    a_tx_min_hold: assert property (st_same && tx_chg |-> tx_n_q >= 153 * C)
        else $error("transmit speed held too briefly");
    a_trail_fixed: assert property (stage_out == 3'h3 && st_same |-> !tx_chg && st_n_q <= 248 * C)
        else $error("trail speed changed or stage too long");
    c_lead: cover property (stage_out == 3'h2 && st_p_q == 3'h0);
    c_trail: cover property (stage_out == 3'h3 && st_p_q == 3'h2);
    c_done: cover property ($rose(done_out));
    c_slow: cover property (stage_out == 3'h1 && st_p_q == 3'h0);
endmodule
bind speed_neg_timing speed_neg_timing_props #(.CYCLES_PER_MS(CYCLES_PER_MS)) speed_neg_timing_props_i (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .link_clk_in(link_clk_in),
    .rx_sync_in(rx_sync_in), .slow_wait_en_in(slow_wait_en_in), .settled_port_state_in(settled_port_state_in),
    .tx_speed_out(tx_speed_out), .rx_speed_out(rx_speed_out), .send_lip_out(send_lip_out),
    .stage_out(stage_out), .done_out(done_out), .signal_out(signal_out));
`default_nettype wire

/* test_speed_neg_timing.sv */
// Self-checking bench for the speed negotiation timing block.
`timescale 1ns/1ps
`default_nettype none
module test_speed_neg_timing;
    localparam integer C = 8;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic slow_en = 1'b0;
    logic settled = 1'b0;
    logic present = 1'b0;
    logic clk_en = 1'b1;
    logic negotiating = 1'b0;
    logic [1:0] hub_speed = 2'h3;
    wire link_clk;
    wire rx_sync;
    wire inserted;
    wire [1:0] tx_speed;
    wire [1:0] rx_speed;
    wire send_lip;
    wire [2:0] stage;
    wire done;
    wire signal;
    integer n_errors = 0;
    integer checks = 0;
    integer n;
    always #4 clock_in = !clock_in;
    speed_neg_timing #(.CYCLES_PER_MS(C)) speed_neg_timing_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .clk_en_in(clk_en), .link_clk_in(link_clk), .rx_sync_in(rx_sync), .slow_wait_en_in(slow_en),
        .settled_port_state_in(settled), .tx_speed_out(tx_speed), .rx_speed_out(rx_speed),
        .send_lip_out(send_lip), .stage_out(stage), .done_out(done), .signal_out(signal));
    hub_model hub_model_i (.present_in(present), .negotiating_in(negotiating), .hub_speed_in(hub_speed),
        .tx_speed_in(tx_speed), .rx_speed_in(rx_speed), .done_in(done), .link_clk_out(link_clk),
        .rx_sync_out(rx_sync), .inserted_out(inserted));
    task automatic check(input string what, input integer lo, input integer hi, input logic [31:0] got);
    begin
        checks = checks + 1;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            n_errors = n_errors + 1;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    end
    endtask
    task automatic wait_stage(input logic [2:0] s, input integer lim);
    begin
        n = 0;
        while (stage !== s && n < lim)
        begin
            @(negedge clock_in);
            n = n + 1;
        end
    end
    endtask
    task automatic do_reset(input logic [1:0] hs);
    begin
        @(negedge clock_in);
        rst_n_in = 1'b0;
        present = 1'b0;
        hub_speed = hs;
        repeat (4) @(negedge clock_in);
        rst_n_in = 1'b1;
    end
    endtask
    task automatic t_reset_values;
    begin
        check("tx speed", 3, 3, tx_speed);
        check("rx speed", 3, 3, rx_speed);
        check("stage", 0, 0, stage);
        check("done", 0, 0, done);
        check("signal", 0, 0, signal);
        check("lip", 1, 1, send_lip);
        settled = 1'b1;
        repeat (3) @(negedge clock_in);
        check("lip settled", 0, 0, send_lip);
        settled = 1'b0;
        repeat (3) @(negedge clock_in);
        check("lip unsettled", 1, 1, send_lip);
    end
    endtask
    task automatic t_hub_max;
    begin
        do_reset(2'h3);
        present = 1'b1;
        negotiating = 1'b1;
        wait_stage(3'h2, 125 * C);
        check("wait to lead", 1, 120 * C + 8, n);
        check("signal", 1, 1, signal);
        check("lead tx", 3, 3, tx_speed);
        check("hub holds port", 0, 0, inserted);
        wait_stage(3'h3, 40 * C);
        check("quick lead", 29 * C, 31 * C, n);
        wait_stage(3'h4, 260 * C);
        check("trail time", 246 * C, 248 * C, n);
        check("done", 1, 1, done);
        repeat (2) @(negedge clock_in);
        check("lip after done", 0, 0, send_lip);
        check("hub inserts on done", 1, 1, inserted);
        negotiating = 1'b0;
        // A frozen block must not notice the lost signal until the enable returns.
        clk_en = 1'b0;
        present = 1'b0;
        repeat (40) @(negedge clock_in);
        check("frozen done", 1, 1, done);
        check("frozen stage", 4, 4, stage);
        clk_en = 1'b1;
        repeat (40) @(negedge clock_in);
        check("done after loss", 0, 0, done);
        check("stage after loss", 0, 0, stage);
    end
    endtask
    task automatic t_hub_low;
    begin
        do_reset(2'h1);
        present = 1'b1;
        wait_stage(3'h2, 125 * C);
        check("wait to lead", 1, 120 * C + 8, n);
        check("lead tx", 3, 3, tx_speed);
        check("lead rx", 1, 1, rx_speed);
        check("hub bypasses", 0, 0, inserted);
        wait_stage(3'h3, 700 * C);
        check("lead time", 641 * C, 643 * C, n);
        check("trail tx", 1, 1, tx_speed);
        check("hub inserts", 1, 1, inserted);
        check("lip in trail", 1, 1, send_lip);
    end
    endtask
    task automatic t_slow;
        logic [1:0] t;
    begin
        do_reset(2'h0);
        slow_en = 1'b1;
        wait_stage(3'h1, 1010 * C);
        check("slow entry", 999 * C, 1002 * C, n);
        t = tx_speed;
        n = 0;
        while (tx_speed === t && n < 200 * C)
        begin
            @(negedge clock_in);
            n = n + 1;
        end
        check("slow dwell", 183 * C, 185 * C, n);
        hub_speed = rx_speed;
        present = 1'b1;
        wait_stage(3'h2, 200 * C);
        check("slow exit", 1, 190 * C, n);
        slow_en = 1'b0;
    end
    endtask
    task automatic finish_test;
    begin
        $display("Errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask
    initial
    begin
        do_reset(2'h3);
        t_reset_values();
        t_hub_max();
        t_hub_low();
        t_slow();
        finish_test();
    end
    // The scenarios need about 145 us; the margin covers a slow stage that never ends.
    initial
    begin
        #400000;
        n_errors = n_errors + 1;
        finish_test();
    end
endmodule
`default_nettype wire
